// *** gcm_pkg.sv ***
// constants shared by the cbr mapper, the de-mapper and their link
// assumes both ends run on one clock and share these figures unchanged
package gcm_pkg;

  // ==========================================================
  // server frame geometry
  localparam int M_BYTES = 2;                  // bytes per payload block
  localparam int BLK_W   = 8 * M_BYTES;        // block width m in bits
  localparam int P_SRV   = 16;                 // payload blocks per frame
  localparam int POS_W   = 5;                  // frame position width
  localparam int ACC_W   = 6;                  // holds up to 2*P_SRV-1
  localparam int CNT_W   = 10;                 // entity count width
  localparam int OH_W    = 8;                  // overhead field width

  localparam logic [POS_W-1:0] POS_OH   = 5'h00; // overhead position
  localparam logic [POS_W-1:0] POS_ONE  = 5'h01; // first payload position
  localparam logic [POS_W-1:0] POS_LAST = 5'h10; // last payload position
  localparam logic [ACC_W-1:0] ACC_P    = 6'h10; // capacity, accumulator width
  localparam logic [CNT_W-1:0] CNT_P    = 10'h010; // capacity, count width

  // ==========================================================
  // granularity: n=8 by default, n=1 on request
  localparam int SH_N8   = 3;                  // bits per byte, log2
  localparam int SH_BYTE = 1;                  // log2(m/n) for n=8
  localparam int SH_BIT  = 4;                  // log2(m/n) for n=1
  localparam logic [CNT_W-1:0] RATIO_BYTE = 10'h002; // m/n for n=8
  localparam logic [CNT_W-1:0] RATIO_BIT  = 10'h010; // m/n for n=1

  // ==========================================================
  // buffers
  localparam int BUF_AW    = 6;                // buffer address width
  localparam int BUF_DEPTH = 64;               // buffer bytes
  localparam logic [BUF_AW:0] FILL_FULL = 7'h40; // buffer full
  localparam logic [BUF_AW:0] FILL_HI   = 7'h30; // too full: send more
  localparam logic [BUF_AW:0] FILL_LO   = 7'h08; // too empty: send fewer
  localparam logic [BUF_AW:0] PTR_STEP  = 7'h02; // pointer step per block

  // ==========================================================
  // client clock regeneration: bits per frame period
  localparam logic [CNT_W-1:0] NCO_MOD  = 10'h088; // 17 cycles * 8 bits

endpackage

// *** gcm_link_if.sv ***
// server link between the cbr mapper and the de-mapper
// assumes both ends share one clock; the testbench joins them here
`timescale 1ns/1ns
interface gcm_link_if;

  // ==========================================================
  // server word stream: one overhead word, then the payload blocks
  logic [gcm_pkg::BLK_W-1:0] srv_data; // overhead or payload block
  logic                      srv_oh;   // marks the overhead word

  modport mapper   (output srv_data, output srv_oh);
  modport demapper (input  srv_data, input  srv_oh);

endinterface

// *** gcm_mapper.sv ***
// cbr mapper: client bytes into a server frame with a sigma-delta pattern
// assumes client strobes are on CLK and the de-mapper reads gcm_link_if
//
// What this block and the de-mapper do
// - fresh entity count measured every server frame
// - fractional rate gives floor, floor+1 sequence
// - block count never exceeds payload capacity
// - count first, overhead next, then payload
// - client written continuously, read by count
// - de-mapper extracts count, gates writes, regenerates clock
// - position j data when j*count mod P below count
// - accumulator cleared at every frame start
// - sum below capacity: store, mark stuff
// - sum at capacity: subtract, store, mark data
// - both ends same start value and count
// - start-up slips: first de-mapper tick finds its buffer empty, sets BUF_ERR
// - byte timing granularity by default
// - single-bit timing granularity selectable
// - payload placed in blocks of M bytes
// - leftover entities signalled in overhead
// - residual is count minus ratio times blocks, taken before fill steering and limits
// - server timing independent of client timing
// - residual sum reaching m/n adds one block
// - fill level steers extra or fewer blocks
`timescale 1ns/1ns
module gcm_mapper (
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic       GRAN_BIT,
  input  wire logic [7:0] CLIENT_DATA,
  input  wire logic       CLIENT_VALID,
  output logic            BUF_OVF,
  gcm_link_if.mapper      LINK
);

  // ==========================================================
  // declarations
  logic [gcm_pkg::POS_W-1:0]  pos_reg;       // frame position, 0 = overhead
  logic [gcm_pkg::POS_W-1:0]  pos_next;      // next frame position
  logic [gcm_pkg::CNT_W-1:0]  arr_reg;       // client bytes this frame
  logic [gcm_pkg::CNT_W-1:0]  rsum_reg;      // running residual sum
  logic [gcm_pkg::CNT_W-1:0]  rsum_next;     // next residual sum
  logic [gcm_pkg::CNT_W-1:0]  cm_reg;        // block count of this frame
  logic [gcm_pkg::ACC_W-1:0]  acc_reg;       // sigma-delta accumulator
  logic [gcm_pkg::ACC_W-1:0]  acc_sum;       // accumulator plus count
  logic [gcm_pkg::BUF_AW:0]   wr_ptr_reg;    // buffer write pointer
  logic [gcm_pkg::BUF_AW:0]   rd_ptr_reg;    // buffer read pointer
  logic [gcm_pkg::BUF_AW:0]   fill;          // bytes held in the buffer
  logic [gcm_pkg::BLK_W-1:0]  srv_data_reg;  // link word
  logic                       srv_oh_reg;    // link overhead marker
  logic                       ovf_reg;       // sticky buffer overflow
  logic                       is_data;       // this position carries data
  logic [gcm_pkg::BLK_W-1:0]  blk;           // next block from the buffer
  logic [7:0]                 buf_mem [gcm_pkg::BUF_DEPTH]; // client buffer
  // count computation terms
  logic [gcm_pkg::CNT_W-1:0]  cn;            // entities in last frame
  logic [gcm_pkg::CNT_W-1:0]  ratio;         // m/n
  logic [gcm_pkg::CNT_W-1:0]  cm_base;       // floor(cn*n/m)
  logic [gcm_pkg::CNT_W-1:0]  cnd;           // leftover entities
  logic [gcm_pkg::CNT_W-1:0]  rsum;          // residual sum before carry
  logic                       carry;         // residual sum wrapped
  logic [gcm_pkg::CNT_W-1:0]  cm_acc;        // count after residual carry
  logic [gcm_pkg::CNT_W-1:0]  resid;         // signed residual for overhead
  logic [gcm_pkg::CNT_W-1:0]  cm_adj;        // count after fill steering
  logic [gcm_pkg::CNT_W-1:0]  avail;         // whole blocks in the buffer
  logic [gcm_pkg::CNT_W-1:0]  cm_fin;        // count sent this frame

  assign fill = wr_ptr_reg - rd_ptr_reg;

  // ==========================================================
  // free-running frame timing, blind to client strobes
  always_comb begin
    if (pos_reg == gcm_pkg::POS_LAST) begin
      pos_next = gcm_pkg::POS_OH;
    end else begin
      pos_next = pos_reg + gcm_pkg::POS_ONE;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pos_reg <= 5'h00;
    end else begin
      pos_reg <= pos_next;
    end
  end

  // ==========================================================
  // arrival counter: bytes seen over the last frame period
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      arr_reg <= 10'h000;
    end else if (pos_reg == gcm_pkg::POS_OH) begin
      arr_reg <= gcm_pkg::CNT_W'(CLIENT_VALID);
    end else begin
      arr_reg <= arr_reg + gcm_pkg::CNT_W'(CLIENT_VALID);
    end
  end

  // ==========================================================
  // per-frame count: entities, blocks, residual and steering
  always_comb begin
    // entity size n: 1 bit or 8 bits
    if (GRAN_BIT) begin
      cn      = arr_reg << gcm_pkg::SH_N8;
      ratio   = gcm_pkg::RATIO_BIT;
      cm_base = cn >> gcm_pkg::SH_BIT;
      cnd     = cn - (cm_base << gcm_pkg::SH_BIT);
    end else begin
      cn      = arr_reg;
      ratio   = gcm_pkg::RATIO_BYTE;
      cm_base = cn >> gcm_pkg::SH_BYTE;
      cnd     = cn - (cm_base << gcm_pkg::SH_BYTE);
    end
    // leftover entities carry into a block when they reach m/n
    rsum  = rsum_reg + cnd;
    carry = (rsum >= ratio);
    if (carry) begin
      rsum_next = rsum - ratio;
      resid     = cnd - ratio;
    end else begin
      rsum_next = rsum;
      resid     = cnd;
    end
    cm_acc = cm_base + gcm_pkg::CNT_W'(carry);
    // buffer fill steers the count while the rate settles
    if (fill > gcm_pkg::FILL_HI) begin
      cm_adj = cm_acc + 10'h001;
    end else if ((fill < gcm_pkg::FILL_LO) && (cm_acc != 10'h000)) begin
      cm_adj = cm_acc - 10'h001;
    end else begin
      cm_adj = cm_acc;
    end
    // never promise more blocks than held or than fit
    avail = gcm_pkg::CNT_W'(fill >> gcm_pkg::SH_BYTE);
    if (cm_adj > avail) begin
      cm_fin = avail;
    end else if (cm_adj > gcm_pkg::CNT_P) begin
      cm_fin = gcm_pkg::CNT_P;
    end else begin
      cm_fin = cm_adj;
    end
  end

  // ==========================================================
  // count and residual sum, updated in the overhead slot
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cm_reg   <= 10'h000;
      rsum_reg <= 10'h000;
    end else if (pos_reg == gcm_pkg::POS_OH) begin
      cm_reg   <= cm_fin;
      rsum_reg <= rsum_next;
    end
  end

  // ==========================================================
  // sigma-delta data/stuff decision per payload position
  always_comb begin
    acc_sum = acc_reg + gcm_pkg::ACC_W'(cm_reg);
    is_data = (acc_sum >= gcm_pkg::ACC_P);
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_reg <= 6'h00;
    end else if (pos_reg == gcm_pkg::POS_OH) begin
      acc_reg <= 6'h00;
    end else if (is_data) begin
      acc_reg <= acc_sum - gcm_pkg::ACC_P;
    end else begin
      acc_reg <= acc_sum;
    end
  end

  // ==========================================================
  // client buffer: writes follow the client, reads follow the count
  always_ff @(posedge CLK) begin
    if (CLIENT_VALID && (fill != gcm_pkg::FILL_FULL)) begin
      buf_mem[wr_ptr_reg[gcm_pkg::BUF_AW-1:0]] <= CLIENT_DATA;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_ptr_reg <= 7'h00;
      ovf_reg    <= 1'b0;
    end else if (CLIENT_VALID) begin
      if (fill != gcm_pkg::FILL_FULL) begin
        wr_ptr_reg <= wr_ptr_reg + 7'h01;
      end else begin
        ovf_reg <= 1'b1;                         // byte lost, flag it
      end
    end
  end

  // block assembly: first buffered byte in the low lane
  genvar k;
  generate
    for (k = 0; k < gcm_pkg::M_BYTES; k++) begin : g_lane
      assign blk[8*k +: 8] =
        buf_mem[rd_ptr_reg[gcm_pkg::BUF_AW-1:0] + gcm_pkg::BUF_AW'(k)];
    end
  endgenerate

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_ptr_reg <= 7'h00;
    end else if ((pos_reg != gcm_pkg::POS_OH) && is_data) begin
      rd_ptr_reg <= rd_ptr_reg + gcm_pkg::PTR_STEP;
    end
  end

  // ==========================================================
  // link word: overhead {residual, count}, then data or stuff
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      srv_data_reg <= 16'h0000;
      srv_oh_reg   <= 1'b0;
    end else if (pos_reg == gcm_pkg::POS_OH) begin
      srv_data_reg <= {resid[gcm_pkg::OH_W-1:0],
                       cm_fin[gcm_pkg::OH_W-1:0]};
      srv_oh_reg   <= 1'b1;
    end else if (is_data) begin
      srv_data_reg <= blk;
      srv_oh_reg   <= 1'b0;
    end else begin
      srv_data_reg <= 16'h0000;
      srv_oh_reg   <= 1'b0;
    end
  end

  // ==========================================================
  // outputs
  assign LINK.srv_data = srv_data_reg;
  assign LINK.srv_oh   = srv_oh_reg;
  assign BUF_OVF       = ovf_reg;

endmodule

// *** gcm_demapper.sv ***
// cbr de-mapper: server frame back to a paced client byte stream
// assumes the mapper drives gcm_link_if on the same clock
`timescale 1ns/1ns
module gcm_demapper (
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic       GRAN_BIT,
  gcm_link_if.demapper    LINK,
  output logic [7:0]      CLIENT_DATA,
  output logic            CLIENT_VALID,
  output logic            BUF_ERR
);

  // ==========================================================
  // declarations
  logic [gcm_pkg::POS_W-1:0] pos_reg;      // payload position, 0 = idle
  logic [gcm_pkg::CNT_W-1:0] cm_reg;       // block count from overhead
  logic [gcm_pkg::CNT_W-1:0] cn_reg;       // entity count from overhead
  logic [gcm_pkg::CNT_W-1:0] cm_in;        // count field
  logic [gcm_pkg::CNT_W-1:0] resid_in;     // residual, sign extended
  logic [gcm_pkg::ACC_W-1:0] acc_reg;      // sigma-delta accumulator
  logic [gcm_pkg::ACC_W-1:0] acc_sum;      // accumulator plus count
  logic                      wr_en;        // this block is client data
  logic [gcm_pkg::BUF_AW:0]  wr_ptr_reg;   // buffer write pointer
  logic [gcm_pkg::BUF_AW:0]  rd_ptr_reg;   // buffer read pointer
  logic [gcm_pkg::BUF_AW:0]  fill;         // bytes held
  logic [7:0]                buf_mem [gcm_pkg::BUF_DEPTH]; // client buffer
  logic [gcm_pkg::CNT_W-1:0] nco_reg;      // client clock phase, bits
  logic [gcm_pkg::CNT_W-1:0] nco_step;     // bits per cycle step
  logic [gcm_pkg::CNT_W-1:0] nco_sum;      // phase plus step
  logic                      tick;         // one client byte due
  logic [7:0]                data_reg;     // client byte out
  logic                      valid_reg;    // client byte strobe
  logic                      err_reg;      // sticky slip flag

  assign fill = wr_ptr_reg - rd_ptr_reg;

  // ==========================================================
  // overhead fields and count recovery
  always_comb begin
    cm_in    = gcm_pkg::CNT_W'(LINK.srv_data[gcm_pkg::OH_W-1:0]);
    resid_in = {{(gcm_pkg::CNT_W-gcm_pkg::OH_W){LINK.srv_data[gcm_pkg::BLK_W-1]}},
                LINK.srv_data[gcm_pkg::BLK_W-1:gcm_pkg::OH_W]};
    acc_sum  = acc_reg + gcm_pkg::ACC_W'(cm_reg);
    wr_en    = (pos_reg != gcm_pkg::POS_OH) && (acc_sum >= gcm_pkg::ACC_P);
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cm_reg <= 10'h000;
      cn_reg <= 10'h000;
    end else if (LINK.srv_oh) begin
      cm_reg <= cm_in;
      if (GRAN_BIT) begin
        cn_reg <= (cm_in << gcm_pkg::SH_BIT) + resid_in;
      end else begin
        cn_reg <= (cm_in << gcm_pkg::SH_BYTE) + resid_in;
      end
    end
  end

  // ==========================================================
  // payload walk with the same accumulator as the mapper
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pos_reg <= 5'h00;
      acc_reg <= 6'h00;
    end else if (LINK.srv_oh) begin
      pos_reg <= gcm_pkg::POS_ONE;
      acc_reg <= 6'h00;
    end else if (pos_reg != gcm_pkg::POS_OH) begin
      if (pos_reg == gcm_pkg::POS_LAST) begin
        pos_reg <= gcm_pkg::POS_OH;
      end else begin
        pos_reg <= pos_reg + gcm_pkg::POS_ONE;
      end
      if (wr_en) begin
        acc_reg <= acc_sum - gcm_pkg::ACC_P;
      end else begin
        acc_reg <= acc_sum;
      end
    end
  end

  // ==========================================================
  // buffer write, gated by the data/stuff pattern
  always_ff @(posedge CLK) begin
    if (wr_en) begin
      for (int i = 0; i < gcm_pkg::M_BYTES; i++) begin
        buf_mem[wr_ptr_reg[gcm_pkg::BUF_AW-1:0] + gcm_pkg::BUF_AW'(i)] <=
          LINK.srv_data[8*i +: 8];
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_ptr_reg <= 7'h00;
    end else if (wr_en) begin
      wr_ptr_reg <= wr_ptr_reg + gcm_pkg::PTR_STEP;
    end
  end

  // ==========================================================
  // client clock: spread cn entities over one frame period
  always_comb begin
    if (GRAN_BIT) begin
      nco_step = cn_reg;
    end else begin
      nco_step = cn_reg << gcm_pkg::SH_N8;
    end
    nco_sum = nco_reg + nco_step;
    tick    = (nco_sum >= gcm_pkg::NCO_MOD);
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      nco_reg <= 10'h000;
    end else if (tick) begin
      nco_reg <= nco_sum - gcm_pkg::NCO_MOD;
    end else begin
      nco_reg <= nco_sum;
    end
  end

  // read out one byte per tick; an empty buffer is a slip
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_ptr_reg <= 7'h00;
      data_reg   <= 8'h00;
      valid_reg  <= 1'b0;
      err_reg    <= 1'b0;
    end else begin
      valid_reg <= 1'b0;
      if (tick && (fill != 7'h00)) begin
        data_reg   <= buf_mem[rd_ptr_reg[gcm_pkg::BUF_AW-1:0]];
        valid_reg  <= 1'b1;
        rd_ptr_reg <= rd_ptr_reg + 7'h01;
      end else if (tick) begin
        err_reg <= 1'b1;                            // underflow
      end
      if (wr_en && (fill > (gcm_pkg::FILL_FULL - gcm_pkg::PTR_STEP))) begin
        err_reg <= 1'b1;                            // overflow
      end
    end
  end

  // ==========================================================
  // outputs
  assign CLIENT_DATA  = data_reg;
  assign CLIENT_VALID = valid_reg;
  assign BUF_ERR      = err_reg;

endmodule

// *** gcm_link_checker.sv ***
// concurrent checks on the server link between the cbr mapper and de-mapper
// assumes tb_top places it beside gcm_link_if on the same clock and reset
`timescale 1ns/1ns
module gcm_link_checker (
  input wire logic                      CLK,
  input wire logic                      RST_N,
  input wire logic                      GRAN_BIT,
  input wire logic [gcm_pkg::BLK_W-1:0] srv_data,
  input wire logic                      srv_oh
);
  // ==========================================================
  // reference frame position and sigma-delta accumulator
  logic        [4:0] pos_reg; // 0 before first overhead, then 1..17
  logic        [7:0] cm_reg;  // block count of the frame on the link
  logic        [8:0] acc_reg; // reference accumulator, wide enough
  logic        [8:0] sum_w;   // accumulator plus count at this position
  logic signed [7:0] res_w;   // residual field of the overhead word

  assign sum_w = acc_reg + {1'h0, cm_reg};
  assign res_w = srv_data[15:8];

  // follow the frame; accumulator restarts at every overhead word
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pos_reg <= 5'h00;
      cm_reg  <= 8'h00;
      acc_reg <= 9'h000;
    end else if (srv_oh) begin
      pos_reg <= 5'h01;
      cm_reg  <= srv_data[7:0];
      acc_reg <= 9'h000;
    end else if (pos_reg != 5'h00 && pos_reg != 5'h11) begin
      pos_reg <= pos_reg + 5'h01;
      acc_reg <= (sum_w < 9'h010) ? sum_w : sum_w - 9'h010;
    end
  end

  // ==========================================================
  // assertions
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_oh_period; srv_oh |-> ##17 srv_oh; endproperty
  a_oh_period: assert property (p_oh_period)
    else $error("overhead word not repeated after 17 cycles");
  property p_oh_gap; (srv_oh && pos_reg != 5'h00) |-> pos_reg == 5'h11; endproperty
  a_oh_gap: assert property (p_oh_gap)
    else $error("overhead word before 16 payload blocks");
  property p_cm_cap; srv_oh |-> srv_data[7:0] <= 8'h10; endproperty
  a_cm_cap: assert property (p_cm_cap)
    else $error("block count above payload capacity");
  property p_res;
    srv_oh |-> (GRAN_BIT ? (res_w >= -8'sh0F && res_w <= 8'sh0F)
                         : (res_w >= -8'sh01 && res_w <= 8'sh01));
  endproperty
  a_res: assert property (p_res)
    else $error("residual outside its range");
  property p_start; $rose(RST_N) |-> ##[0:1] (srv_oh && srv_data[7:0] == 8'h00); endproperty
  a_start: assert property (p_start)
    else $error("no empty overhead word after reset");
  property p_pos1; (srv_oh && srv_data[7:0] < 8'h10) |=> srv_data == 16'h0000; endproperty
  a_pos1: assert property (p_pos1)
    else $error("first payload position not stuff");
  property p_empty; (srv_oh && srv_data[7:0] == 8'h00) |=> (srv_data == 16'h0000) [*8]; endproperty
  a_empty: assert property (p_empty)
    else $error("data in a frame with zero count");
  property p_stuff_zero;
    (pos_reg != 5'h00 && pos_reg != 5'h11 && !srv_oh && sum_w < 9'h010) |-> srv_data == 16'h0000;
  endproperty
  a_stuff_zero: assert property (p_stuff_zero)
    else $error("stuff position carries data");

  // main scenarios reached
  c_bit: cover property (srv_oh && GRAN_BIT && srv_data[7:0] != 8'h00);
  c_busy: cover property (srv_oh && srv_data[7:0] > 8'h08);
  c_neg: cover property (srv_oh && res_w < 8'sh00);
endmodule

// *** tb_top.sv ***
// self-checking bench: mapper and de-mapper joined over the server link
// assumes gcm_pkg, gcm_link_if, both ends and the checker compile first
`timescale 1ns/1ns
module tb_top;
  // ==========================================================
  // signals and bookkeeping
  typedef struct {logic gran; int gap; int nbytes; logic exp_ovf;} gcm_row_type;
  gcm_row_type rows [6];      // ordinary cases: rate, granularity, result
  logic        clk;           // 125 MHz
  logic        rst_n;         // asynchronous reset
  logic        gran_bit;      // granularity for both ends
  logic        tx_valid;      // client byte strobe
  logic        buf_ovf;       // mapper refusal flag
  logic        rx_valid;      // recovered byte strobe
  logic        buf_err;       // de-mapper error flag
  logic        in_frame;      // a frame is being counted
  logic [7:0]  tx_data;       // client byte
  logic [7:0]  rx_data;       // recovered byte
  logic [7:0]  next_byte;     // never zero, so data blocks show
  logic [7:0]  cm_seen;       // count of the frame being counted
  logic [7:0]  exp_q [$];     // bytes sent, awaiting recovery
  int          failures;      // mismatches
  int          checks_done;   // comparisons
  int          nz_cnt;        // non-stuff blocks in the frame
  int          rx_cnt;        // bytes recovered in this test
  int          idx;           // wait bound

  // ==========================================================
  // the two ends and the checker
  gcm_link_if gcm_link_if_i ();
  gcm_mapper gcm_mapper_i (.CLK(clk), .RST_N(rst_n), .GRAN_BIT(gran_bit),
    .CLIENT_DATA(tx_data), .CLIENT_VALID(tx_valid), .BUF_OVF(buf_ovf), .LINK(gcm_link_if_i));
  gcm_demapper gcm_demapper_i (.CLK(clk), .RST_N(rst_n), .GRAN_BIT(gran_bit),
    .LINK(gcm_link_if_i), .CLIENT_DATA(rx_data), .CLIENT_VALID(rx_valid), .BUF_ERR(buf_err));
  gcm_link_checker gcm_link_checker_i (.CLK(clk), .RST_N(rst_n), .GRAN_BIT(gran_bit),
    .srv_data(gcm_link_if_i.srv_data), .srv_oh(gcm_link_if_i.srv_oh));

  // clock generator
  initial clk = 1'h0;
  always #4 clk = ~clk;

  // compare and count
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // counts, verdict, end of run
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // reset for 12 cycles, then wait for the first overhead word
  task do_reset(input logic gran);
    rst_n = 1'h0;
    gran_bit = gran;
    tx_valid = 1'h0;
    exp_q.delete();
    in_frame = 1'h0;
    rx_cnt = 0;
    repeat (12) @(negedge clk);
    rst_n = 1'h1;
    for (idx = 0; idx < 4 && gcm_link_if_i.srv_oh !== 1'h1; idx++) @(negedge clk);
    if (gcm_link_if_i.srv_oh !== 1'h1) begin
      failures++;
      test_done();
    end
  endtask

  // n client bytes, gap idle cycles after each
  task send(input int gap, input int n);
    for (int k = 0; k < n; k++) begin
      tx_data = next_byte;
      tx_valid = 1'h1;
      exp_q.push_back(next_byte);
      next_byte = (next_byte == 8'hFF) ? 8'h01 : next_byte + 8'h01;
      @(negedge clk);
      if (gap > 0) begin
        tx_valid = 1'h0;
        repeat (gap) @(negedge clk);
      end
    end
    tx_valid = 1'h0;
  endtask

  // ==========================================================
  // monitor: recovered order, data blocks per frame, residual
  always @(negedge clk) begin
    if (rst_n === 1'h1) begin
      if (rx_valid === 1'h1) begin
        rx_cnt++;
        if (exp_q.size() == 0) check("rx_extra", 16'h0001, 16'h0000);
        else check("rx_data", rx_data, exp_q.pop_front());
      end
      if (gcm_link_if_i.srv_oh === 1'h1) begin
        if (in_frame) check("data_blocks", 16'(nz_cnt), cm_seen);
        if (gran_bit) check("bit_residual", gcm_link_if_i.srv_data[10:8], 3'h0);
        cm_seen = gcm_link_if_i.srv_data[7:0];
        nz_cnt = 0;
        in_frame = 1'h1;
      end else if (gcm_link_if_i.srv_data !== 16'h0000) begin
        nz_cnt++;
      end
    end
  end

  // watchdog
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    test_done();
  end

  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'h0; gran_bit = 1'h0; tx_valid = 1'h0; tx_data = 8'h00; in_frame = 1'h0;
    failures = 0; checks_done = 0; nz_cnt = 0; rx_cnt = 0; next_byte = 8'h01; cm_seen = 8'h00;
    rows[0] = '{1'h0, 0, 120, 1'h0};
    rows[1] = '{1'h0, 1, 100, 1'h0};
    rows[2] = '{1'h0, 3, 80, 1'h0};
    rows[3] = '{1'h1, 0, 120, 1'h0};
    rows[4] = '{1'h1, 2, 90, 1'h0};
    rows[5] = '{1'h0, 5, 60, 1'h0};
    foreach (rows[r]) begin
      do_reset(rows[r].gran);
      send(rows[r].gap, rows[r].nbytes);
      repeat (300) @(negedge clk);
      check("buf_ovf", buf_ovf, rows[r].exp_ovf);
      check("rx_seen", rx_cnt != 0, 1'h1);
      $display("test row %0d done", r);
    end
    // client rate step without reset
    do_reset(1'h0);
    send(0, 100);
    send(3, 60);
    repeat (300) @(negedge clk);
    check("step_ovf", buf_ovf, 1'h0);
    check("step_rx", rx_cnt != 0, 1'h1);
    $display("test rate step done");
    // reset in mid traffic, then bit granularity again
    send(0, 40);
    rst_n = 1'h0;
    #1;
    check("rst_oh", gcm_link_if_i.srv_oh, 1'h0);
    check("rst_data", gcm_link_if_i.srv_data, 16'h0000);
    check("rst_rx", rx_valid, 1'h0);
    check("rst_flags", {buf_ovf, buf_err}, 2'h0);
    do_reset(1'h1);
    send(1, 40);
    repeat (300) @(negedge clk);
    check("rerun_rx", rx_cnt != 0, 1'h1);
    $display("test mid reset done");
    test_done();
  end
endmodule
